/* File: dio_consts.svh */
`ifndef DIO_CONSTS_SVH
`define DIO_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses).
// ----------------------------------------------------------------------------
`define DIO_OFS_CFG0     8'h00
`define DIO_OFS_EDGE     8'h18
`define DIO_OFS_MODE     8'h1C
`define DIO_OFS_LEVEL    8'h20
`define DIO_OFS_READ     8'h40
`define DIO_OFS_STATUS   8'h28
`define DIO_OFS_CLEAR    8'h2C
`define DIO_OFS_ENABLE   8'h30
`define DIO_OFS_ERRCODE  8'h34
// ----------------------------------------------------------------------------
// Field positions of a line configuration word and of the edge register.
// ----------------------------------------------------------------------------
`define DIO_FN_LSB       0
`define DIO_ACT_LSB      4
`define DIO_ACTV_BIT     8
`define DIO_TRIG_BOTH_BIT 6
// ----------------------------------------------------------------------------
// Status bit positions.
// ----------------------------------------------------------------------------
`define DIO_ST_TRIG      0
`define DIO_ST_EVENT     1
`define DIO_ST_PULSE     2
`define DIO_ST_REJECT    3
`define DIO_ST_RDERR     4
// ----------------------------------------------------------------------------
// Reset values, error code and timing.
// ----------------------------------------------------------------------------
`define DIO_EDGE_RST     6'h00
`define DIO_ERR_NOT_MAN  16'd508
`define DIO_PULSE_NS     10000
`define DIO_CLK_MHZ      200
`define DIO_PULSE_CYC    ((`DIO_PULSE_NS * `DIO_CLK_MHZ) / 1000)
`endif

/* File: dio_pkg.sv */
package dio_pkg;
  // Line functions.
  typedef enum logic [2:0] {
    FN_AUTO         = 3'h0,
    EVENT_INPUT_FN  = 3'h1,
    STATUS_OUTPUT_FN = 3'h2,
    FN_MANUAL       = 3'h3
  } fn_e;
  // Actions share one code space; meaning depends on the function.
  typedef enum logic [3:0] {
    TURN_OUTPUT_ON_ACTION  = 4'h0,
    TURN_OUTPUT_OFF_ACTION = 4'h1,
    SEQUENCE_BEGIN_ACTION  = 4'h2,
    SEQUENCE_HALT_ACTION   = 4'h3,
    FULL_ACTION            = 4'h4,
    EMPTY_ACTION           = 4'h5,
    REGULATION_STATE_ACTION = 4'h6,
    END_ACTION             = 4'h7,
    SOURCE_STATE_ACTION    = 4'h8,
    FIXED_HIGH_ACTION      = 4'h9,
    FIXED_LOW_ACTION       = 4'hA,
    STATIC_DRIVE_HIGH      = 4'hB,
    STATIC_DRIVE_LOW       = 4'hC,
    STATIC_READ_ACTION     = 4'hD
  } act_e;
  typedef struct packed {
    fn_e  fn;
    act_e act;
  } line_cfg_s;
  // Instrument-side conditions that status outputs reflect.
  typedef struct packed {
    logic full;
    logic empty;
    logic regulation_state_action;
    logic end_flag;
    logic source_on;
  } cond_s;
  // Protection trips feeding the line 3 pulse.
  typedef struct packed {
    logic overvoltage_trip;
    logic overcurrent_trip;
    logic overtemp_trip;
    logic sense_reverse;
  } protection_trip_s;
  // One-cycle action requests toward the instrument.
  typedef struct packed {
    logic output_on;
    logic output_off;
    logic seq_begin;
    logic seq_halt;
  } action_req_s;
endpackage

/* File: dio_line_ctrl.sv */
`include "dio_consts.svh"

module dio_line_ctrl #(
  parameter int unsigned PULSE_CYC = `DIO_PULSE_CYC
) (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire logic [5:0]                   line_in,
  output logic      [5:0]                   line_out,
  output logic      [5:0]                   line_oe,
  input  wire dio_pkg::cond_s               cond,
  input  wire dio_pkg::protection_trip_s    trips,
  output dio_pkg::action_req_s              action_req,
  output logic                              trigger_pulse,
  output logic                              irq
);

  // --------------------------------------------------------------------------
  // Line configuration store.
  // --------------------------------------------------------------------------
  dio_pkg::line_cfg_s cfg_q [6];
  logic [5:0]  edge_fall_q;
  logic        trig_both_q;   // Line 1 trigger fires on either edge.
  logic [1:0]  mode_q;        // Bit 0 simulator mode, bit 1 test mode.
  logic [4:0]  status_q;
  logic [4:0]  enable_q;
  logic [15:0] errcode_q;

  // --------------------------------------------------------------------------
  // AHB-Lite address phase capture.
  // --------------------------------------------------------------------------
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [7:0]  addr_q;
  logic [31:0] rdata_q;
  wire  take = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      addr_q    <= take ? haddr[7:0] : addr_q;
    end
  end

  // --------------------------------------------------------------------------
  // Input synchronisers and edge detection.
  // --------------------------------------------------------------------------
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] prev_q;

  // The first stage is read only by the second to avoid metastable fan-out.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      prev_q  <= 6'h00;
    end else begin
      sync1_q <= line_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  wire [5:0] rise = sync2_q & ~prev_q;
  wire [5:0] fall = ~sync2_q & prev_q;
  // Edge selected by each line's edge setting.
  wire [5:0] sel_edge = (edge_fall_q & fall) | (~edge_fall_q & rise);

  // --------------------------------------------------------------------------
  // Write decode and legality check.
  // --------------------------------------------------------------------------
  wire [7:0] waddr    = addr_q;
  wire       cfg_hit  = wr_pend_q & (waddr < 8'h18) & (waddr[1:0] == 2'b00);
  wire [2:0] cfg_idx  = waddr[4:2];           // Zero-based line index 0..5.
  wire [2:0] wfn      = hwdata[`DIO_FN_LSB +: 3];
  wire [3:0] wact_raw = hwdata[`DIO_ACT_LSB +: 4];
  wire       wact_vld = hwdata[`DIO_ACTV_BIT];

  // Auto-capable lines are 1 and 3, zero-based 0 and 2.
  function automatic logic is_auto_line(input logic [2:0] idx);
    is_auto_line = (idx == 3'd0) || (idx == 3'd2);
  endfunction

  // Action defaults when the write carries no action.
  function automatic logic [3:0] dflt_act(input logic [2:0] fn);
    case (fn)
      3'h1:    dflt_act = 4'h0;
      3'h2:    dflt_act = 4'h9;
      3'h3:    dflt_act = 4'hD;
      default: dflt_act = 4'h0;
    endcase
  endfunction

  wire [3:0] wact = wact_vld ? wact_raw : dflt_act(wfn);
  wire sim_m  = mode_q[0];
  wire test_m = mode_q[1];

  logic cfg_ok;
  // Mode gating rejects actions the present mode does not support.
  always_comb begin
    cfg_ok = 1'b0;
    case (wfn)
      3'h0: cfg_ok = is_auto_line(cfg_idx);
      3'h1: cfg_ok = !is_auto_line(cfg_idx) && (wact <= 4'h3) &&
                     ((wact <= 4'h1) || test_m);
      3'h2: cfg_ok = !is_auto_line(cfg_idx) && (wact >= 4'h4) &&
                     (wact <= 4'hA) &&
                     (((wact != 4'h4) && (wact != 4'h5)) || sim_m) &&
                     (((wact != 4'h6) && (wact != 4'h7)) || test_m);
      3'h3: cfg_ok = (wact >= 4'hB) && (wact <= 4'hD);
      default: cfg_ok = 1'b0;
    endcase
  end

  wire cfg_wr  = cfg_hit & cfg_ok;
  wire cfg_rej = cfg_hit & ~cfg_ok;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 6; i++) begin
        cfg_q[i] <= is_auto_line(3'(i)) ?
          '{dio_pkg::FN_AUTO, dio_pkg::TURN_OUTPUT_ON_ACTION} :
          '{dio_pkg::FN_MANUAL, dio_pkg::STATIC_READ_ACTION};
      end
    end else if (cfg_wr) begin
      cfg_q[cfg_idx] <= '{dio_pkg::fn_e'(wfn), dio_pkg::act_e'(wact)};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_fall_q <= `DIO_EDGE_RST;
      trig_both_q <= 1'b0;
      mode_q      <= 2'b01;
      enable_q    <= 5'h00;
    end else if (wr_pend_q) begin
      if (waddr == `DIO_OFS_EDGE) begin
        edge_fall_q <= hwdata[5:0];
        trig_both_q <= hwdata[`DIO_TRIG_BOTH_BIT];
      end
      if (waddr == `DIO_OFS_MODE)   mode_q      <= hwdata[1:0];
      if (waddr == `DIO_OFS_ENABLE) enable_q    <= hwdata[4:0];
    end
  end

  // --------------------------------------------------------------------------
  // Line behaviour per function.
  // --------------------------------------------------------------------------
  function automatic logic cond_level(input logic [3:0] a,
                                      input dio_pkg::cond_s c);
    case (a)
      4'h4:    cond_level = c.full;
      4'h5:    cond_level = c.empty;
      4'h6:    cond_level = c.regulation_state_action;
      4'h7:    cond_level = c.end_flag;
      4'h8:    cond_level = c.source_on;
      4'hA:    cond_level = 1'b0;
      default: cond_level = 1'b1;
    endcase
  endfunction

  logic [5:0] drv_val;
  logic [5:0] drv_en;
  logic [5:0] evt_fire;
  logic [5:0] is_min;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      drv_val[i]  = 1'b0;
      drv_en[i]   = 1'b0;
      evt_fire[i] = 1'b0;
      is_min[i]   = 1'b0;
      case (cfg_q[i].fn)
        dio_pkg::STATUS_OUTPUT_FN: begin
          // Falling polarity inverts the driven condition.
          drv_val[i] = cond_level(cfg_q[i].act, cond) ^ edge_fall_q[i];
          drv_en[i]  = 1'b1;
        end
        dio_pkg::EVENT_INPUT_FN: begin
          evt_fire[i] = sel_edge[i];
        end
        dio_pkg::FN_MANUAL: begin
          drv_en[i]  = (cfg_q[i].act != dio_pkg::STATIC_READ_ACTION);
          drv_val[i] = (cfg_q[i].act == dio_pkg::STATIC_DRIVE_HIGH);
          is_min[i]  = ~drv_en[i];
        end
        default: begin
        end
      endcase
    end
  end

  // Line 1 trigger takes its edge setting, or both edges when asked for.
  wire trig_edge = trig_both_q ? (rise[0] | fall[0]) : sel_edge[0];
  wire trig_fire = (cfg_q[0].fn == dio_pkg::FN_AUTO) & trig_edge;
  wire any_trip  = |trips;
  wire pulse_en  = (cfg_q[2].fn == dio_pkg::FN_AUTO);

  // --------------------------------------------------------------------------
  // Protection pulse on line 3.
  // --------------------------------------------------------------------------
  logic        trip_prev_q;
  logic [15:0] pulse_cnt_q;
  wire         trip_rise = any_trip & ~trip_prev_q;

  // Only a fresh trip starts a pulse, so a held trip yields one pulse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trip_prev_q <= 1'b0;
      pulse_cnt_q <= 16'h0000;
    end else begin
      trip_prev_q <= any_trip;
      if (pulse_en && trip_rise && pulse_cnt_q == 16'h0000)
        pulse_cnt_q <= 16'(PULSE_CYC);
      else if (pulse_cnt_q != 16'h0000)
        pulse_cnt_q <= pulse_cnt_q - 16'h0001;
    end
  end
  wire pulse_on = pulse_cnt_q != 16'h0000;

  // --------------------------------------------------------------------------
  // Event action requests toward the instrument.
  // --------------------------------------------------------------------------
  logic [3:0] act_bits;
  always_comb begin
    act_bits = 4'h0;
    for (int i = 0; i < 6; i++) begin
      if (evt_fire[i]) act_bits[cfg_q[i].act[1:0]] = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Manual read, status and error code.
  // --------------------------------------------------------------------------
  // Each line has its own read word; a line not set to static read returns 0 and flags a read error.
  wire [7:0] rd_ofs  = haddr[7:0] - `DIO_OFS_READ;
  wire       rd_win  = (haddr[7:0] >= `DIO_OFS_READ) & (rd_ofs < 8'h18);
  wire [2:0] rd_idx  = rd_ofs[4:2];
  wire       rd_take = take & ~hwrite & rd_win;
  wire       rd_bad  = rd_take & ~is_min[rd_idx];

  wire [4:0] ev_set;
  assign ev_set[`DIO_ST_TRIG]   = trig_fire;
  assign ev_set[`DIO_ST_EVENT]  = |evt_fire;
  assign ev_set[`DIO_ST_PULSE]  = pulse_en & trip_rise & ~pulse_on;
  assign ev_set[`DIO_ST_REJECT] = cfg_rej;
  assign ev_set[`DIO_ST_RDERR]  = rd_bad;
  wire clr_hit = wr_pend_q & (waddr == `DIO_OFS_CLEAR);
  wire [4:0] clr = clr_hit ? hwdata[4:0] : 5'h00;

  // A set in the same cycle as its clear wins, so no event is lost.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q  <= 5'h00;
      errcode_q <= 16'h0000;
    end else begin
      status_q  <= (status_q & ~clr) | ev_set;
      if (rd_bad) errcode_q <= `DIO_ERR_NOT_MAN;
      else if (clr[`DIO_ST_RDERR]) errcode_q <= 16'h0000;
    end
  end

  // Read data selection for the data phase.
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (haddr[7:0] < 8'h18) begin
      rmux[3:0]  = {1'b0, cfg_q[haddr[4:2]].fn};
      rmux[7:4]  = cfg_q[haddr[4:2]].act;
    end else if (rd_win) begin
      rmux[0]    = rd_bad ? 1'b0 : sync2_q[rd_idx];
    end else begin
      case (haddr[7:0])
        `DIO_OFS_EDGE:    rmux[6:0]  = {trig_both_q, edge_fall_q};
        `DIO_OFS_MODE:    rmux[1:0]  = mode_q;
        `DIO_OFS_LEVEL:   rmux[5:0]  = sync2_q;
        `DIO_OFS_STATUS:  rmux[4:0]  = status_q;
        `DIO_OFS_ENABLE:  rmux[4:0]  = enable_q;
        `DIO_OFS_ERRCODE: rmux[15:0] = errcode_q;
        default:          rmux       = 32'h0000_0000;
      endcase
    end
  end

  // Line 3 carries the protection pulse only while it is automatic; any
  // other function drives it like the remaining lines.
  wire line3_val = pulse_en ? pulse_on : drv_val[2];
  wire line3_en  = pulse_en | drv_en[2];

  // --------------------------------------------------------------------------
  // Registered outputs.
  // --------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q       <= 32'h0000_0000;
      line_out      <= 6'h00;
      line_oe       <= 6'h00;
      action_req    <= '0;
      trigger_pulse <= 1'b0;
      irq           <= 1'b0;
    end else begin
      rdata_q       <= (take & ~hwrite) ? rmux : 32'h0000_0000;
      line_out      <= {drv_val[5:3], line3_val, drv_val[1:0]};
      line_oe       <= {drv_en[5:3], line3_en, drv_en[1:0]};
      action_req    <= {act_bits[0], act_bits[1], act_bits[2], act_bits[3]};
      trigger_pulse <= trig_fire;
      irq           <= |((status_q & ~clr | ev_set) & enable_q);
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule

/* File: dio_line_ctrl_properties.sv */
module dio_line_ctrl_props #(
  parameter int unsigned PULSE_CYC = 2000
) (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic                      hready,
  input  wire logic [31:0]               hrdata,
  input  wire logic [5:0]                line_in,
  input  wire logic [5:0]                line_out,
  input  wire logic [5:0]                line_oe,
  input  wire dio_pkg::protection_trip_s trips,
  input  wire dio_pkg::action_req_s      action_req,
  input  wire logic                      trigger_pulse
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ---------------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------------
  logic        in0_q;
  logic [3:0]  in0_age_q;
  logic [15:0] run_q;
  logic        rd_q;
  logic [2:0]  wr_age_q;
  wire         take_w = hsel & hready & htrans[1];

  // Ages saturate so a long quiet spell cannot wrap into the legal window.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in0_q     <= 1'b0;
      in0_age_q <= 4'hF;
      run_q     <= 16'h0;
      rd_q      <= 1'b0;
      wr_age_q  <= 3'h0;
    end else begin
      in0_q     <= line_in[0];
      in0_age_q <= (line_in[0] != in0_q) ? 4'h0 :
                   (in0_age_q == 4'hF) ? 4'hF : in0_age_q + 4'h1;
      run_q     <= line_out[2] ? run_q + 16'h1 : 16'h0;
      rd_q      <= take_w & !hwrite;
      wr_age_q  <= (take_w & hwrite) ? 3'h0 :
                   (wr_age_q == 3'h7) ? 3'h7 : wr_age_q + 3'h1;
    end
  end

  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  AST_RST_DEFAULT: assert property ($rose(hresetn) |-> ##2
    (line_oe == 6'h04 && line_out == 6'h00))
    else $error("line drive after reset is wrong");
  AST_TRIG_ONE: assert property (trigger_pulse |=> !trigger_pulse)
    else $error("trigger pulse longer than one cycle");
  AST_TRIG_LAT: assert property (trigger_pulse |->
    in0_age_q inside {[1:8]})
    else $error("trigger without a recent pin edge");
  AST_PULSE_LEN: assert property (line_oe[2] && $fell(line_out[2]) |->
    run_q == PULSE_CYC)
    else $error("protection pulse width wrong");
  AST_PULSE_GO: assert property ($rose(|trips) && !line_out[2] |->
    ##[1:4] line_out[2])
    else $error("protection pulse missing");
  AST_ACT_ONE: assert property (|action_req |=> action_req == 4'h0)
    else $error("action request longer than one cycle");
  AST_RD_IDLE: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  AST_OE_CAUSE: assert property ($changed(line_oe) |->
    wr_age_q <= 3'h4)
    else $error("line enable changed without a write");

  COV_TRIG: cover property (trigger_pulse);
  COV_PULSE: cover property ($fell(line_out[2]));
  COV_ACT: cover property (action_req.output_on);
endmodule

bind dio_line_ctrl dio_line_ctrl_props #(.PULSE_CYC(PULSE_CYC)) i_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .line_in(line_in),
  .line_out(line_out), .line_oe(line_oe), .trips(trips),
  .action_req(action_req), .trigger_pulse(trigger_pulse));

/* File: dio_ext_equip.sv */
module dio_ext_equip (
  input  wire logic [5:0] line_out,
  input  wire logic [5:0] line_oe,
  input  wire logic [5:0] ext_lvl,
  output logic      [5:0] line_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // A driven pin reads back its own level; otherwise the equipment drives it.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      line_in[i] = line_oe[i] ? line_out[i] : ext_lvl[i];
    end
  end
endmodule

/* File: dio_line_ctrl_bench.sv */
`include "dio_consts.svh"
module dio_line_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PCYC = 20;
  logic                      hclk = 1'b0;
  logic                      hresetn = 1'b0;
  logic                      hsel = 1'b0;
  logic [31:0]               haddr = 32'h0;
  logic [1:0]                htrans = 2'h0;
  logic                      hwrite = 1'b0;
  logic [2:0]                hsize = 3'h2;
  logic [31:0]               hwdata = 32'h0;
  logic [5:0]                ext_lvl = 6'h00;
  dio_pkg::cond_s            cond = '0;
  dio_pkg::protection_trip_s trips = '0;
  wire logic                 hready;
  logic [31:0]               hrdata;
  logic                      hresp;
  logic [5:0]                line_in, line_out, line_oe;
  dio_pkg::action_req_s      action_req;
  logic                      trigger_pulse, irq, rd_dp = 1'b0, r;
  logic [63:0]               rq[$];
  logic [4:0]                eq[$];
  logic [4:0]                e5;
  int                        error_cnt = 0;
  int                        n_checks = 0;

  always #2.5 hclk = ~hclk;

  dio_line_ctrl #(.PULSE_CYC(PCYC)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .cond(cond), .trips(trips),
    .action_req(action_req), .trigger_pulse(trigger_pulse), .irq(irq));
  dio_ext_equip i_ext (.line_out(line_out), .line_oe(line_oe),
    .ext_lvl(ext_lvl), .line_in(line_in));

  // -----------------------------------------------------------------------
  // Comparison and bus tasks
  // -----------------------------------------------------------------------
  task automatic cmp(logic [31:0] g, logic [31:0] e, string m);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_pin(logic [31:0] g, logic [31:0] e);
    cmp(g, e, "pin level");
  endtask
  task automatic chk_rd(logic [31:0] g, logic [31:0] e);
    cmp(g, e, "read data");
  endtask
  task automatic chk_ev(logic [4:0] g, logic [4:0] e);
    cmp(32'(g), 32'(e), "event");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Single transfer; the master never assumes a wait count.
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
                     logic [31:0] e, logic [31:0] m);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    rd_dp <= !w;
    if (!w) rq.push_back({e, m});
    do @(posedge hclk); while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask
  task automatic step();
    repeat (3) @(posedge hclk);
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
    bus(1'b0, a, 32'h0, e, m);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 32'h0);
  endtask
  task automatic cfg(int ln, dio_pkg::fn_e f, dio_pkg::act_e a, logic g);
    wr(`DIO_OFS_CFG0 + 8'(4 * (ln - 1)), {23'h0, g, a, 1'b0, f});
    step();
  endtask
  // Pin changes are spaced well beyond the synchroniser depth.
  task automatic tog(int i, logic v, logic [4:0] ev);
    if (ev != 5'h0) eq.push_back(ev);
    @(posedge hclk);
    ext_lvl[i] <= v;
    repeat (10) @(posedge hclk);
  endtask
  task automatic pulse(int b);
    int n;
    n = 0;
    @(posedge hclk);
    trips <= dio_pkg::protection_trip_s'(4'(1 << b));
    repeat (8) if (line_out[2] !== 1'b1) @(posedge hclk);
    while (line_out[2] === 1'b1 && n < 100) begin
      n++;
      @(posedge hclk);
    end
    chk_pin(32'(n), PCYC);
    trips <= '0;
  endtask

  // -----------------------------------------------------------------------
  // Result monitor: every read data phase and every event takes a note.
  // -----------------------------------------------------------------------
  always @(posedge hclk) begin
    if (rd_dp && hready === 1'b1) begin
      cmp(32'(hresp), 32'h0, "response");
      if (rq.size() == 0) cmp(32'h1, 32'h0, "stray read");
      else begin
        chk_rd(hrdata & rq[0][31:0], rq[0][63:32]);
        void'(rq.pop_front());
      end
    end
    if ({trigger_pulse, action_req} !== 5'h0) begin
      if (eq.size() == 0) cmp(32'h1, 32'h0, "unexpected event");
      else chk_ev({trigger_pulse, action_req}, eq.pop_front());
    end
  end

  // Watchdog sized well above the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    print_verdict();
  end

  // -----------------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h5455));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    step();
    chk_pin(32'(line_oe), 32'h04);
    chk_pin(32'(line_out), 32'h00);
    rd(`DIO_OFS_EDGE, 32'h0, 32'h3F);
    wr(`DIO_OFS_ENABLE, 32'h1F);
    cfg(2, dio_pkg::FN_AUTO, dio_pkg::TURN_OUTPUT_ON_ACTION, 1'b0);
    rd(`DIO_OFS_STATUS, 32'h8, 32'h8);
    chk_pin(32'(irq), 32'h1);
    wr(`DIO_OFS_CLEAR, 32'h8);
    step();
    chk_pin(32'(irq), 32'h0);
    tog(1, 1'b1, 5'h00);
    tog(1, 1'b0, 5'h00);
    tog(0, 1'b1, 5'h10);
    tog(0, 1'b0, 5'h00);
    wr(`DIO_OFS_EDGE, 32'h1);
    tog(0, 1'b1, 5'h00);
    tog(0, 1'b0, 5'h10);
    wr(`DIO_OFS_EDGE, 32'h40);
    tog(0, 1'b1, 5'h10);
    tog(0, 1'b0, 5'h10);
    wr(`DIO_OFS_EDGE, 32'h0);
    cfg(2, dio_pkg::EVENT_INPUT_FN, dio_pkg::SEQUENCE_HALT_ACTION, 1'b0);
    tog(1, 1'b1, 5'h08);
    tog(1, 1'b0, 5'h00);
    wr(`DIO_OFS_MODE, 32'h2);
    for (int i = 0; i < 3; i++) begin
      cfg(2, dio_pkg::EVENT_INPUT_FN, dio_pkg::act_e'(4'(i + 1)), 1'b1);
      tog(1, 1'b1, 5'(4 >> i));
      tog(1, 1'b0, 5'h00);
    end
    wr(`DIO_OFS_MODE, 32'h1);
    cfg(2, dio_pkg::EVENT_INPUT_FN, dio_pkg::SEQUENCE_BEGIN_ACTION, 1'b1);
    rd(`DIO_OFS_STATUS, 32'h8, 32'h8);
    tog(1, 1'b1, 5'h01);
    tog(1, 1'b0, 5'h00);
    cfg(4, dio_pkg::STATUS_OUTPUT_FN, dio_pkg::FIXED_LOW_ACTION, 1'b0);
    chk_pin({line_oe[3], line_out[3]}, 32'h3);
    cfg(4, dio_pkg::STATUS_OUTPUT_FN, dio_pkg::FULL_ACTION, 1'b1);
    repeat (3) begin
      @(posedge hclk);
      cond <= dio_pkg::cond_s'($urandom);
      step();
      chk_pin(32'(line_out[3]), 32'(cond.full));
    end
    cfg(4, dio_pkg::STATUS_OUTPUT_FN, dio_pkg::REGULATION_STATE_ACTION, 1'b1);
    chk_pin(32'(line_out[3]), 32'(cond.full));
    wr(`DIO_OFS_MODE, 32'h2);
    for (int i = 0; i < 5; i++) begin
      @(posedge hclk);
      cond <= dio_pkg::cond_s'($urandom);
      step();
      e5 = {cond.regulation_state_action, cond.end_flag, cond.source_on, 2'b00};
      cfg(4, dio_pkg::STATUS_OUTPUT_FN,
          dio_pkg::act_e'(i == 4 ? 4'h5 : 4'(i + 6 + (i / 3))), 1'b1);
      chk_pin(32'(line_out[3]), 32'(e5[4 - i]));
    end
    cfg(6, dio_pkg::FN_MANUAL, dio_pkg::STATIC_DRIVE_HIGH, 1'b1);
    chk_pin({line_oe[5], line_out[5]}, 32'h3);
    cfg(6, dio_pkg::FN_MANUAL, dio_pkg::STATIC_DRIVE_LOW, 1'b1);
    chk_pin({line_oe[5], line_out[5]}, 32'h2);
    cfg(6, dio_pkg::FN_MANUAL, dio_pkg::FIXED_HIGH_ACTION, 1'b0);
    chk_pin(32'(line_oe[5]), 32'h0);
    r = 1'($urandom);
    @(posedge hclk);
    ext_lvl[4] <= r;
    ext_lvl[5] <= !r;
    step();
    rd(`DIO_OFS_READ + 8'h10, 32'(r), 32'h1);
    rd(`DIO_OFS_READ + 8'h14, 32'(!r), 32'h1);
    cfg(5, dio_pkg::STATUS_OUTPUT_FN, dio_pkg::FIXED_HIGH_ACTION, 1'b1);
    rd(`DIO_OFS_READ + 8'h10, 32'h0, 32'hFFFFFFFF);
    rd(`DIO_OFS_ERRCODE, 32'd508, 32'hFFFF);
    rd(`DIO_OFS_STATUS, 32'h10, 32'h10);
    wr(`DIO_OFS_CLEAR, 32'h1F);
    wr(`DIO_OFS_ENABLE, 32'h0);
    for (int b = 0; b < 4; b++) pulse(b);
    chk_pin(32'(irq), 32'h0);
    rd(`DIO_OFS_STATUS, 32'h4, 32'h4);
    wr(`DIO_OFS_ENABLE, 32'h4);
    step();
    chk_pin(32'(irq), 32'h1);
    wr(`DIO_OFS_CLEAR, 32'h1F);
    step();
    chk_pin(32'(irq), 32'h0);
    chk_pin(32'(eq.size() + rq.size()), 32'h0);
    print_verdict();
  end
endmodule
